// ---- verilog/source_transfer_control.sv ----
// The register offsets and the APB interface to the registers were left to the implementer.
module source_transfer_control
  import sts_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC_DEF,
  parameter int OVL_LIMIT = OVL_LIMIT_DEF
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  src_ok_pin,
  input  wire logic [1:0]  phase_bad_pin,
  input  wire logic        scr_fault_pin,
  input  wire logic        zero_cur_pin,
  input  wire logic [7:0]  phase_diff,
  input  wire logic [7:0]  load_pct,
  input  wire logic        ser_valid,
  input  wire logic [3:0]  ser_cmd,
  output logic [1:0]       scr_on,
  output logic             load_lost
);

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0]  m1_q;
  logic [5:0]  m2_q;
  logic [1:0]  ok_s;
  logic [1:0]  pbad_s;
  logic        scr_s;
  logic        zc_s;
  logic [15:0] ms_cnt_q;
  logic [9:0]  sec_cnt_q;
  logic        ms_tick;
  logic        sec_tick;
  cfg_s        cfg_q;
  cfg_s        live_q;
  times_s      times_q;
  logic [15:0] pass_q;
  logic        unlock_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic        hit;
  logic        wr;
  cmd_s        bus_cmd;
  cmd_s        rem_cmd;
  cmd_s        cmd;
  logic        man_req_q;
  logic        man_tgt_q;
  logic        man_hold_q;
  logic [7:0]  man_tmr_q;
  logic [7:0]  ret_tmr_q;
  logic [15:0] acc_q;
  logic        trip;
  logic        alm;
  logic [1:0]  good;
  logic        in_sync;
  logic        ret_due;
  st_e         st_q;
  logic        act_q;
  logic        tgt_q;
  logic        inh_ovl_q;
  logic        refused_q;
  logic [7:0]  tmr_q;
  logic [1:0]  scr_on_q;
  logic        lost_q;
  stat_s       stat;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m1_q <= 6'h00;
      m2_q <= 6'h00;
    end
    else
    begin
      m1_q <= {zero_cur_pin, scr_fault_pin, phase_bad_pin, src_ok_pin};
      m2_q <= m1_q;
    end
  end

  assign ok_s   = m2_q[1:0];
  assign pbad_s = m2_q[3:2];
  assign scr_s  = m2_q[4];
  assign zc_s   = m2_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // millisecond and second enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_cnt_q  <= 16'h0000;
      sec_cnt_q <= 10'h000;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
      if (ms_tick)
      begin
        sec_cnt_q <= sec_tick ? 10'h000 : sec_cnt_q + 10'h001;
      end
    end
  end

  assign ms_tick  = (ms_cnt_q == 16'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (sec_cnt_q == SEC_MS - 10'h001);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlock_q <= 1'b0;
    end
    else if (wr && paddr == ADDR_UNLOCK)
    begin
      unlock_q <= (pwdata[15:0] == pass_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q   <= CFG_RST;
      times_q <= TIME_RST;
      pass_q  <= PASS_RST;
    end
    else if (wr && unlock_q)
    begin
      case (paddr)
        ADDR_CFG:  cfg_q <= cfg_s'(pwdata[13:0]);
        ADDR_TIME: times_q <= '{
                     win:  pwdata[31:24],
                     dead: clamp(pwdata[23:16], DEAD_MIN_MS, DEAD_MAX_MS),
                     hold: clamp(pwdata[15:8], HOLD_MIN_S, HOLD_MAX_S),
                     ret:  clamp(pwdata[7:0], RET_MIN_S, RET_MAX_S)};
        ADDR_PASS: pass_q <= pwdata[15:0];
        default:   pass_q <= pass_q;
      endcase
    end
  end

  always_comb
  begin
    hit  = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      ADDR_CFG:    rd_d = {18'h00000, cfg_q};
      ADDR_TIME:   rd_d = times_q;
      ADDR_UNLOCK: rd_d = {31'h0000_0000, unlock_q};
      ADDR_PASS:   rd_d = 32'h0000_0000;
      ADDR_CMD:    rd_d = 32'h0000_0000;
      ADDR_STAT:   rd_d = stat;
      default:     hit = 1'b0;
    endcase
  end

  // passcode never reads back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commands from bus and serial port
  assign bus_cmd = (wr && paddr == ADDR_CMD) ? cmd_s'(pwdata[3:0]) : cmd_s'(4'h0);
  assign rem_cmd = (ser_valid && cfg_q.remote) ? cmd_s'(ser_cmd) : cmd_s'(4'h0);
  assign cmd     = cmd_s'(bus_cmd | rem_cmd);

  ////////////////////////////////////////////////////////////////////////////
  // snapshot only while idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      live_q <= CFG_RST;
    end
    else if (st_q == ST_FEED || st_q == ST_LOST)
    begin
      live_q <= cfg_q;
    end
  end

  assign good = ok_s & ~(pbad_s & {2{live_q.phase_chk}});
  assign alm  = live_q.scr_chk && scr_s;
  assign in_sync = (phase_diff <= times_q.win);

  ////////////////////////////////////////////////////////////////////////////
  // manual request, a pending one holds off return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      man_req_q  <= 1'b0;
      man_tgt_q  <= 1'b0;
      man_hold_q <= 1'b0;
      man_tmr_q  <= 8'h00;
    end
    else if (cmd.auto_sel)
    begin
      man_req_q  <= 1'b0;
      man_hold_q <= 1'b0;
    end
    else if (cmd.to_s1 || cmd.to_s2)
    begin
      man_req_q <= 1'b1;
      man_tgt_q <= cmd.to_s2;
      man_tmr_q <= 8'h00;
    end
    else if (man_req_q)
    begin
      if (st_q == ST_FEED && act_q == man_tgt_q)
      begin
        man_req_q  <= 1'b0;
        man_hold_q <= 1'b1;
      end
      else if (live_q.man_m == MM_SWIFT && sec_tick)
      begin
        man_tmr_q <= man_tmr_q + 8'h01;
        if (man_tmr_q + 8'h01 >= MAN_TO_S)
        begin
          man_req_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return wait, seconds on alternative with preferred good
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ret_tmr_q <= 8'h00;
    end
    else if (st_q == ST_FEED && act_q != live_q.pref && good[live_q.pref]
             && live_q.ret_en && !man_hold_q && !man_req_q)
    begin
      if (sec_tick && ret_tmr_q != RET_MAX_S)
      begin
        ret_tmr_q <= ret_tmr_q + 8'h01;
      end
    end
    else
    begin
      ret_tmr_q <= 8'h00;
    end
  end

  assign ret_due = live_q.ret_en && act_q != live_q.pref && good[live_q.pref]
                   && !man_hold_q && !man_req_q && ret_tmr_q >= times_q.ret;

  ////////////////////////////////////////////////////////////////////////////
  // excess integrated per ms
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= 16'h0000;
    end
    else if (!live_q.ovl_en || st_q == ST_INHIBIT)
    begin
      acc_q <= 16'h0000;
    end
    else if (ms_tick)
    begin
      if (load_pct > LOAD_FULL && acc_q < 16'hFF00)
      begin
        acc_q <= acc_q + {8'h00, load_pct - LOAD_FULL};
      end
      else if (load_pct <= LOAD_FULL && acc_q != 16'h0000)
      begin
        acc_q <= acc_q - 16'h0001;
      end
    end
  end

  assign trip = live_q.ovl_en && (acc_q >= 16'(OVL_LIMIT));

  ////////////////////////////////////////////////////////////////////////////
  // transfer state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q      <= ST_LOST;
      act_q     <= 1'b0;
      tgt_q     <= 1'b0;
      inh_ovl_q <= 1'b0;
      refused_q <= 1'b0;
      tmr_q     <= 8'h00;
    end
    else
    begin
      case (st_q)
        ST_FEED:
        begin
          tmr_q <= 8'h00;
          if (trip || alm)
          begin
            st_q      <= ST_INHIBIT;
            inh_ovl_q <= trip;
          end
          else if (!good[act_q])
          begin
            tgt_q <= !act_q;
            if (good[!act_q])
            begin
              if (in_sync || live_q.nsync == NS_ZERO)
              begin
                st_q <= ST_ZWAIT;
              end
              else if (live_q.nsync == NS_DELAY)
              begin
                st_q <= ST_DEAD;
              end
              else
              begin
                st_q      <= ST_LOST;
                refused_q <= 1'b1;
              end
            end
            else if (!live_q.stay)
            begin
              st_q <= ST_LOST;
            end
          end
          else if (man_req_q && man_tgt_q != act_q && good[man_tgt_q])
          begin
            tgt_q <= man_tgt_q;
            if (live_q.man_m == MM_ZERO)
            begin
              st_q <= ST_ZWAIT;
            end
            else if (in_sync)
            begin
              act_q <= man_tgt_q;
            end
          end
          else if (ret_due)
          begin
            tgt_q <= live_q.pref;
            case (live_q.ret_m)
              RM_ZERO: st_q <= ST_ZWAIT;
              RM_WAIT: st_q <= in_sync ? ST_ZWAIT : ST_FEED;
              RM_DELAY: st_q <= ST_DEAD;
              RM_SWIFT:
              begin
                if (in_sync)
                begin
                  act_q <= live_q.pref;
                end
              end
              default: st_q <= ST_FEED;
            endcase
          end
        end
        ST_ZWAIT:
        begin
          if (trip || alm)
          begin
            st_q      <= ST_INHIBIT;
            inh_ovl_q <= trip;
          end
          else if (!good[tgt_q])
          begin
            st_q <= ST_FEED;
          end
          else if (zc_s)
          begin
            act_q <= tgt_q;
            st_q  <= ST_FEED;
          end
        end
        ST_DEAD:
        begin
          if (ms_tick)
          begin
            tmr_q <= tmr_q + 8'h01;
            if (tmr_q + 8'h01 >= times_q.dead)
            begin
              act_q <= tgt_q;
              st_q  <= ST_FEED;
            end
          end
        end
        ST_INHIBIT:
        begin
          if (sec_tick && tmr_q != HOLD_MAX_S)
          begin
            tmr_q <= tmr_q + 8'h01;
          end
          if (cmd.clr)
          begin
            st_q <= ST_LOST;
          end
          else if ((inh_ovl_q ? live_q.ovl_auto : live_q.inh_auto)
                   && tmr_q >= times_q.hold)
          begin
            st_q <= ST_LOST;
          end
        end
        ST_LOST:
        begin
          tmr_q <= 8'h00;
          // refusal keeps lost source
          // reconnecting elsewhere out of sync would be the refused transfer
          if (good[live_q.pref] && (!refused_q || in_sync || act_q == live_q.pref))
          begin
            act_q     <= live_q.pref;
            st_q      <= ST_FEED;
            refused_q <= 1'b0;
          end
          else if (good[!live_q.pref] && (!refused_q || in_sync || act_q != live_q.pref))
          begin
            act_q     <= !live_q.pref;
            st_q      <= ST_FEED;
            refused_q <= 1'b0;
          end
        end
        default: st_q <= ST_LOST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thyristor drive; make-before-break not attempted, one side at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scr_on_q <= 2'b00;
      lost_q   <= 1'b1;
    end
    else
    begin
      if (st_q == ST_FEED || st_q == ST_ZWAIT)
      begin
        scr_on_q <= act_q ? 2'b10 : 2'b01;
        lost_q   <= 1'b0;
      end
      else
      begin
        scr_on_q <= 2'b00;
        lost_q   <= 1'b1;
      end
    end
  end

  assign scr_on    = scr_on_q;
  assign load_lost = lost_q;

  assign stat = '{rsvd: 22'h000000, man_pend: man_req_q, in_sync: in_sync,
                  unlocked: unlock_q, ovl_trip: inh_ovl_q, state: 3'(st_q),
                  scr: scr_on_q, act: act_q};

endmodule // source_transfer_control

// ---- verilog/sts_pkg.sv ----
package sts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_TIME   = 8'h04;
  localparam logic [7:0] ADDR_UNLOCK = 8'h08;
  localparam logic [7:0] ADDR_PASS   = 8'h0C;
  localparam logic [7:0] ADDR_CMD    = 8'h10;
  localparam logic [7:0] ADDR_STAT   = 8'h14;

  localparam logic [15:0] PASS_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int CLK_NS     = 20;
  localparam int MS_NS      = 1000000;
  localparam int MS_CYC_DEF = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] SEC_MS = 10'h3E8;

  // limits in seconds, milliseconds or degrees as named
  localparam logic [7:0] RET_MIN_S  = 8'h10;
  localparam logic [7:0] RET_MAX_S  = 8'h7F;
  localparam logic [7:0] RET_RST_S  = 8'h10;
  localparam logic [7:0] HOLD_MIN_S = 8'h08;
  localparam logic [7:0] HOLD_MAX_S = 8'h40;
  localparam logic [7:0] HOLD_RST_S = 8'h0A;
  localparam logic [7:0] DEAD_MIN_MS = 8'h14;
  localparam logic [7:0] DEAD_MAX_MS = 8'hFF;
  localparam logic [7:0] DEAD_RST_MS = 8'h18;
  localparam logic [7:0] WIN_RST_DEG = 8'h14;
  localparam logic [7:0] MAN_TO_S    = 8'h1E;
  localparam logic [7:0] LOAD_FULL   = 8'h64;
  localparam int OVL_LIMIT_DEF = 20000;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {NS_ZERO, NS_DELAY, NS_DISABLE, NS_SPARE} nsync_e;
  typedef enum logic [1:0] {RM_ZERO, RM_WAIT, RM_DELAY, RM_SWIFT} retm_e;
  typedef enum logic {MM_ZERO, MM_SWIFT} manm_e;
  typedef enum logic [2:0] {ST_FEED, ST_ZWAIT, ST_DEAD, ST_INHIBIT, ST_LOST} st_e;

  typedef struct packed {
    logic   stay;
    manm_e  man_m;
    logic   scr_chk;
    logic   phase_chk;
    retm_e  ret_m;
    logic   remote;
    logic   inh_auto;
    logic   ovl_auto;
    nsync_e nsync;
    logic   ovl_en;
    logic   ret_en;
    logic   pref;
  } cfg_s;

  typedef struct packed {
    logic [7:0] win;
    logic [7:0] dead;
    logic [7:0] hold;
    logic [7:0] ret;
  } times_s;

  typedef struct packed {
    logic clr;
    logic auto_sel;
    logic to_s2;
    logic to_s1;
  } cmd_s;

  typedef struct packed {
    logic [21:0] rsvd;
    logic        man_pend;
    logic        in_sync;
    logic        unlocked;
    logic        ovl_trip;
    logic [2:0]  state;
    logic [1:0]  scr;
    logic        act;
  } stat_s;

  localparam cfg_s CFG_RST = '{
    stay: 1'b0, man_m: MM_SWIFT, scr_chk: 1'b1, phase_chk: 1'b1,
    ret_m: RM_SWIFT, remote: 1'b1, inh_auto: 1'b0, ovl_auto: 1'b1,
    nsync: NS_ZERO, ovl_en: 1'b0, ret_en: 1'b1, pref: 1'b0};

  localparam times_s TIME_RST = '{
    win: WIN_RST_DEG, dead: DEAD_RST_MS, hold: HOLD_RST_S, ret: RET_RST_S};

endpackage

// ---- tb/sts_props.sv ----
module sts_props
  import sts_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [1:0] src_ok_pin,
  input wire logic [1:0] scr_on,
  input wire logic       load_lost
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && penable;
  endsequence

  sequence s_off;
    load_lost && scr_on == 2'b00;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // zero wait answer
  property p_pready;
    psel |-> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready low");

  property p_err_map;
    s_acc |-> pslverr == (paddr > ADDR_STAT || paddr[1:0] != 2'b00);
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad pslverr");

  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray pslverr");

  property p_one;
    !(scr_on[0] && scr_on[1]);
  endproperty
  a_one: assert property (p_one) else $error("both sources on");

  property p_lost;
    load_lost == (scr_on == 2'b00);
  endproperty
  a_lost: assert property (p_lost) else $error("lost flag wrong");

  property p_rst;
    $rose(presetn) |-> s_off;
  endproperty
  a_rst: assert property (p_rst) else $error("powered at reset");

  property p_conn0;
    $rose(scr_on[0]) |-> $past(src_ok_pin[0], 2);
  endproperty
  a_conn0: assert property (p_conn0) else $error("bad source 1 on");

  property p_conn1;
    $rose(scr_on[1]) |-> $past(src_ok_pin[1], 2);
  endproperty
  a_conn1: assert property (p_conn1) else $error("bad source 2 on");
endmodule // sts_props

bind source_transfer_control sts_props sts_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .src_ok_pin(src_ok_pin), .scr_on(scr_on),
  .load_lost(load_lost)
);

// ---- tb/load_model.sv ----
module load_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] scr_on,
  input  wire logic       zc_hold,
  output logic            zero_cur_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] ph_q;

  // free phase, crossing two cycles in sixteen
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ph_q <= 4'h0;
    else
      ph_q <= ph_q + 4'h1;

  // no source, no current; hold models a slow load
  assign zero_cur_pin = (scr_on == 2'b00) || (!zc_hold && ph_q[3:1] == 3'h0);
endmodule // load_model

// ---- tb/source_transfer_control_tb_top.sv ----
module source_transfer_control_tb_top
  import sts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, ser_valid, zc_hold;
  logic        pready, pslverr, load_lost, zero_cur_pin, scr_fault_pin;
  logic [1:0]  src_ok_pin, scr_on, phase_bad_pin;
  logic [3:0]  ser_cmd;
  logic [7:0]  paddr, phase_diff, load_pct;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          errors, total_checks, cycles, seed;
  cfg_s        cf;

  source_transfer_control #(.MS_CYCLES(5), .OVL_LIMIT(50)) source_transfer_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_ok_pin(src_ok_pin),
    .phase_bad_pin(phase_bad_pin), .scr_fault_pin(scr_fault_pin), .zero_cur_pin(zero_cur_pin),
    .phase_diff(phase_diff), .load_pct(load_pct), .ser_valid(ser_valid),
    .ser_cmd(ser_cmd), .scr_on(scr_on), .load_lost(load_lost)
  );

  load_model load_model_i (
    .pclk(pclk), .presetn(presetn), .scr_on(scr_on), .zc_hold(zc_hold),
    .zero_cur_pin(zero_cur_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic set_cfg;
    apb(1'b1, ADDR_CFG, {18'h0, cf});
  endtask

  task automatic pins(input logic [1:0] ok);
    @(posedge pclk);
    src_ok_pin <= ok;
  endtask

  task automatic ser(input logic [3:0] c);
    @(posedge pclk);
    ser_valid <= 1'b1;
    ser_cmd   <= c;
    @(posedge pclk);
    ser_valid <= 1'b0;
  endtask

  // settle: wait for the state, else look after n cycles
  task automatic out(input logic [2:0] e, input int n, input bit settle);
    repeat (n)
    begin
      @(negedge pclk);
      if (settle && {load_lost, scr_on} === e)
        break;
    end
    check({30'h0, load_lost, scr_on}, {30'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ceiling well above the long hold wait
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      wrap_up;
    end
  end

  // read answers match the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());

  initial
  begin
    seed = 82;
    presetn = 1'b0;
    {psel, penable, pwrite, ser_valid, zc_hold} = 5'h00;
    {ser_cmd, paddr, pwdata} = 44'h0;
    src_ok_pin = 2'b11;
    phase_bad_pin = 2'b00;
    scr_fault_pin = 1'b0;
    phase_diff = 8'h64;
    load_pct = 8'h32;
    cf = CFG_RST;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CFG, 33'h1FA2);
    rd(ADDR_TIME, 33'h14180A10);
    rd(8'h18, 33'h100000000);
    out(3'b001, 20, 1'b1);
    // locked until the factory code
    apb(1'b1, ADDR_CFG, 32'h0);
    rd(ADDR_CFG, 33'h1FA2);
    apb(1'b1, ADDR_UNLOCK, 32'h1234);
    rd(ADDR_UNLOCK, 33'h0);
    apb(1'b1, ADDR_UNLOCK, 32'h0);
    rd(ADDR_UNLOCK, 33'h1);
    apb(1'b1, ADDR_TIME, 32'h140503C8);
    rd(ADDR_TIME, 33'h1414087F);
    // out of phase, transfer refused
    cf.nsync = NS_DISABLE;
    set_cfg;
    phase_diff <= 8'h40 | (8'($random(seed)) & 8'h3F);
    pins(2'b10);
    out(3'b100, 20, 1'b1);
    out(3'b100, 50, 1'b0);
    pins(2'b11);
    out(3'b001, 20, 1'b1);
    // slow load holds off the zero switch
    cf.nsync = NS_ZERO;
    cf.ret_en = 1'b0;
    cf.man_m = MM_ZERO;
    cf.remote = 1'b0;
    set_cfg;
    zc_hold <= 1'b1;
    pins(2'b10);
    out(3'b001, 40, 1'b0);
    @(posedge pclk) zc_hold <= 1'b0;
    out(3'b010, 40, 1'b1);
    pins(2'b11);
    ser(4'h1);
    out(3'b010, 40, 1'b0);
    cf.remote = 1'b1;
    set_cfg;
    ser(4'h1);
    out(3'b001, 40, 1'b1);
    apb(1'b1, ADDR_CMD, 32'h4);
    // dead time of 20 ms is 100 cycles
    cf.nsync = NS_DELAY;
    set_cfg;
    pins(2'b10);
    out(3'b100, 20, 1'b1);
    out(3'b100, 80, 1'b0);
    out(3'b010, 40, 1'b1);
    // overload, manual then automatic recovery
    cf.ovl_en = 1'b1;
    cf.ovl_auto = 1'b0;
    set_cfg;
    @(posedge pclk) load_pct <= 8'hC8;
    out(3'b100, 60, 1'b1);
    @(posedge pclk) load_pct <= 8'($random(seed)) & 8'h3F;
    out(3'b100, 400, 1'b0);
    apb(1'b1, ADDR_CMD, 32'h8);
    out(3'b010, 20, 1'b1);
    cf.ovl_auto = 1'b1;
    set_cfg;
    @(posedge pclk) load_pct <= 8'hC8;
    out(3'b100, 60, 1'b1);
    @(posedge pclk) load_pct <= 8'($random(seed)) & 8'h3F;
    // hold of 8 s, second tick may slip by one
    out(3'b100, 34000, 1'b0);
    out(3'b010, 12500, 1'b1);
    cf.ovl_en = 1'b0;
    set_cfg;
    @(posedge pclk) load_pct <= 8'hC8;
    out(3'b010, 200, 1'b0);
    // thyristor fault inhibits, manual policy by default
    @(posedge pclk) scr_fault_pin <= 1'b1;
    out(3'b100, 20, 1'b1);
    @(posedge pclk) scr_fault_pin <= 1'b0;
    out(3'b100, 100, 1'b0);
    apb(1'b1, ADDR_CMD, 32'h8);
    out(3'b010, 20, 1'b1);
    // phase order check off ignores a bad sequence
    cf.phase_chk = 1'b0;
    set_cfg;
    @(posedge pclk) phase_bad_pin <= 2'b10;
    out(3'b010, 50, 1'b0);
    // check on: lone source now unusable, shut
    cf.phase_chk = 1'b1;
    set_cfg;
    out(3'b100, 20, 1'b1);
    out(3'b100, 40, 1'b0);
    wrap_up;
  end
endmodule // source_transfer_control_tb_top
